//--- pkg/seq_map.svh
// Register offsets, field positions, reset values and timing counts
//
// Summary of operation
// - Reset leaves sequencer asleep until power-on set
// - Start, then proximity, wait, ambient when enabled
// - Power-off skips the wait, runs the cycle's remaining conversions, then sleeps
// - Power-on bit is bit 0, register 0
// - Both light channels integrate, latch together
// - Light results double-buffered against torn reads
// - Duration is 2.72 ms times (256 - setting)
// - Wait counts 2.72 ms steps, 1 to 256
// - Two-bit gain field: 1, 8, 16, 120
// - Proximity diode: infrared, broadband or both
// - Proximity count latched at integration end
// - Drive field picks 100, 25, 12.5 mA sink
// - 1 to 255 emitter pulses, 16 us each
// - One step delay after power-on before start
// - Stretch bit makes wait steps twelve times longer
// - Light end latches data, sets interrupt status
`ifndef SEQ_MAP_SVH
`define SEQ_MAP_SVH

`define ADDR_ENABLE 8'h00
`define ADDR_LIGHT_TIME 8'h01
`define ADDR_NEAR_TIME 8'h02
`define ADDR_PAUSE_TIME 8'h03
`define ADDR_CONFIG 8'h04
`define ADDR_PULSE_COUNT 8'h05
`define ADDR_CONTROL 8'h06
`define ADDR_STATUS 8'h07
`define ADDR_BROAD_LO 8'h08
`define ADDR_BROAD_HI 8'h09
`define ADDR_IR_LO 8'h0A
`define ADDR_IR_HI 8'h0B
`define ADDR_NEAR_LO 8'h0C
`define ADDR_NEAR_HI 8'h0D

`define BIT_POWER_ON 0
`define BIT_LIGHT_EN 1
`define BIT_NEAR_EN 2
`define BIT_PAUSE_EN 3
`define BIT_INT_EN 4
`define BIT_STRETCH 1
`define BIT_LIGHT_VALID 0
`define BIT_NEAR_VALID 1
`define BIT_LIGHT_INT 4
`define POS_GAIN 0
`define POS_DIODE 4
`define POS_DRIVE 6

`define RST_ENABLE 8'h00
`define RST_TIME 8'hFF
`define RST_CONFIG 8'h00
`define RST_PULSE_COUNT 8'h00
`define RST_CONTROL 8'h00

`define CLK_PERIOD_NS 20
`define STEP_TIME_NS 2720000
`define STEP_CYCLES (`STEP_TIME_NS / `CLK_PERIOD_NS)
`define PULSE_PERIOD_NS 16000
`define PULSE_PERIOD_CYCLES (`PULSE_PERIOD_NS / `CLK_PERIOD_NS)
`define PULSE_ON_NS 7300
`define PULSE_ON_CYCLES (`PULSE_ON_NS / `CLK_PERIOD_NS)
`define STRETCH_FACTOR 12

`endif

//--- pkg/seq_pkg.sv
// Types shared by the measurement sequencer
package seq_pkg;

    // Gray along sleep, power-up, start, pulses, integrate, wait, light
    typedef enum logic [2:0] {
        ST_SLEEP = 3'h0,
        ST_POWERUP = 3'h1,
        ST_START = 3'h3,
        ST_NEAR_PULSE = 3'h2,
        ST_NEAR_INTEG = 3'h6,
        ST_PAUSE = 3'h7,
        ST_LIGHT = 3'h5
    } seq_state_e;

    typedef logic [7:0] byte_t;

endpackage : seq_pkg

//--- hdl/step_tick_gen.sv
// Step time base: one-cycle tick every STEP_CYCLES, restartable
`timescale 1ns/100ps
`default_nettype none
`include "seq_map.svh"
module step_tick_gen #(
    parameter int STEP_CYCLES = `STEP_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic restart,
    output logic tick
);
    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic next_tick;

    always_comb begin
        next_tick = 1'b0;
        if (restart) begin
            next_cnt = 32'h0;
        end else if (cnt == 32'(STEP_CYCLES - 1)) begin
            next_cnt = 32'h0;
            next_tick = 1'b1;
        end else begin
            next_cnt = cnt + 32'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 32'h0;
            tick <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tick <= next_tick;
        end
    end
endmodule : step_tick_gen
`default_nettype wire

//--- hdl/emitter_pulse_gen.sv
// Emitter burst: N pulses of fixed period, sink on for part of each
`timescale 1ns/100ps
`default_nettype none
`include "seq_map.svh"
module emitter_pulse_gen #(
    parameter int PERIOD_CYCLES = `PULSE_PERIOD_CYCLES,
    parameter int ON_CYCLES = `PULSE_ON_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Burst control
    input wire logic start,
    input wire logic [7:0] count,
    output logic sink_on,
    output logic done
);
    logic busy;
    logic [15:0] phase;
    logic [7:0] left;
    logic next_busy;
    logic [15:0] next_phase;
    logic [7:0] next_left;
    logic next_sink_on;
    logic next_done;

    always_comb begin
        next_busy = busy;
        next_phase = phase;
        next_left = left;
        next_done = 1'b0;
        if (start) begin
            // A zero count gives no pulse at all
            next_busy = (count != 8'h00);
            next_done = (count == 8'h00);
            next_phase = 16'h0;
            next_left = count;
        end else if (busy) begin
            if (phase == 16'(PERIOD_CYCLES - 1)) begin
                next_phase = 16'h0;
                next_left = left - 8'h01;
                if (left == 8'h01) begin
                    next_busy = 1'b0;
                    next_done = 1'b1;
                end
            end else begin
                next_phase = phase + 16'h1;
            end
        end
        next_sink_on = next_busy && (next_phase < 16'(ON_CYCLES));
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            phase <= 16'h0;
            left <= 8'h00;
            sink_on <= 1'b0;
            done <= 1'b0;
        end else begin
            busy <= next_busy;
            phase <= next_phase;
            left <= next_left;
            sink_on <= next_sink_on;
            done <= next_done;
        end
    end
endmodule : emitter_pulse_gen
`default_nettype wire

//--- hdl/light_prox_measurement_sequencer.sv
// Light and proximity measurement sequencer with its register file
`timescale 1ns/100ps
`default_nettype none
`include "seq_map.svh"
module light_prox_measurement_sequencer #(
    parameter int STEP_CYCLES = `STEP_CYCLES,
    parameter int PULSE_ON_CYCLES = `PULSE_ON_CYCLES
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // Register port
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // Converter results
    input wire logic [15:0] BROADBAND_RESULT,
    input wire logic [15:0] INFRARED_RESULT,
    input wire logic [15:0] NEAR_RESULT,
    // Converter and emitter control
    output logic LIGHT_INTEGRATE,
    output logic NEAR_INTEGRATE,
    output logic [1:0] LIGHT_GAIN_SEL,
    output logic [1:0] NEAR_DIODE_SEL,
    output logic [1:0] EMITTER_DRIVE_SEL,
    output logic EMITTER_SINK_PIN,
    output logic LOW_POWER,
    output logic LIGHT_INT
);
    seq_pkg::seq_state_e state, next_state;
    seq_pkg::byte_t enable, next_enable;
    seq_pkg::byte_t light_integ_time, next_light_integ_time;
    seq_pkg::byte_t near_integ_time, next_near_integ_time;
    seq_pkg::byte_t pause_time, next_pause_time;
    seq_pkg::byte_t config_reg, next_config_reg;
    seq_pkg::byte_t emitter_pulse_count, next_emitter_pulse_count;
    seq_pkg::byte_t control, next_control;
    seq_pkg::byte_t read_value, broad_hi_shadow, next_broad_hi_shadow;
    seq_pkg::byte_t ir_hi_shadow, next_ir_hi_shadow;
    seq_pkg::byte_t near_hi_shadow, next_near_hi_shadow;
    logic [15:0] broadband_count, next_broadband_count;
    logic [15:0] infrared_count, next_infrared_count;
    logic [15:0] near_count, next_near_count;
    logic light_valid, next_light_valid;
    logic near_valid, next_near_valid;
    logic light_int, next_light_int;
    logic [8:0] steps, next_steps;
    logic [3:0] sub, next_sub;
    logic tick;
    logic restart;
    logic pulse_start;
    logic pulse_done;
    logic light_latch;
    logic near_latch;
    logic power_on_bit;
    logic light_enable;
    logic near_enable;
    logic pause_enable;
    logic pause_stretch;
    logic step_hit;

    assign power_on_bit = enable[`BIT_POWER_ON];
    assign light_enable = enable[`BIT_LIGHT_EN];
    assign near_enable = enable[`BIT_NEAR_EN];
    assign pause_enable = enable[`BIT_PAUSE_EN];
    assign pause_stretch = config_reg[`BIT_STRETCH];
    assign restart = (next_state != state);

    // Register setting t gives 256 - t whole steps
    function automatic logic [8:0] step_total(input logic [7:0] t);
        step_total = 9'h100 - {1'b0, t};
    endfunction : step_total

    step_tick_gen #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_tick (
        .clk(CLK_SYS),
        .rst(RST),
        .restart(restart),
        .tick(tick)
    );

    emitter_pulse_gen #(
        .ON_CYCLES(PULSE_ON_CYCLES)
    ) u_pulse (
        .clk(CLK_SYS),
        .rst(RST),
        .start(pulse_start),
        .count(emitter_pulse_count),
        .sink_on(EMITTER_SINK_PIN),
        .done(pulse_done)
    );

    // Sequencer
    always_comb begin
        next_state = state;
        next_steps = steps;
        next_sub = sub;
        pulse_start = 1'b0;
        light_latch = 1'b0;
        near_latch = 1'b0;
        step_hit = 1'b0;
        case (state)
            seq_pkg::ST_SLEEP: begin
                if (power_on_bit) begin
                    next_state = seq_pkg::ST_POWERUP;
                end
            end
            seq_pkg::ST_POWERUP: begin
                if (!power_on_bit) begin
                    next_state = seq_pkg::ST_SLEEP;
                end else if (tick) begin
                    next_state = seq_pkg::ST_START;
                end
            end
            seq_pkg::ST_START: begin
                if (near_enable) begin
                    next_state = seq_pkg::ST_NEAR_PULSE;
                    pulse_start = 1'b1;
                end else if (pause_enable && power_on_bit) begin
                    next_state = seq_pkg::ST_PAUSE;
                end else if (light_enable) begin
                    next_state = seq_pkg::ST_LIGHT;
                end else if (!power_on_bit) begin
                    next_state = seq_pkg::ST_SLEEP;
                end
            end
            seq_pkg::ST_NEAR_PULSE: begin
                if (pulse_done) begin
                    next_state = seq_pkg::ST_NEAR_INTEG;
                end
            end
            seq_pkg::ST_NEAR_INTEG: begin
                step_hit = tick && (steps + 9'h1 == step_total(near_integ_time));
                if (tick) begin
                    next_steps = steps + 9'h1;
                end
                if (step_hit) begin
                    near_latch = 1'b1;
                    // Power-off skips only the wait, never a conversion
                    if (pause_enable && power_on_bit) begin
                        next_state = seq_pkg::ST_PAUSE;
                    end else if (light_enable) begin
                        next_state = seq_pkg::ST_LIGHT;
                    end else begin
                        next_state = power_on_bit ? seq_pkg::ST_START
                                                  : seq_pkg::ST_SLEEP;
                    end
                end
            end
            seq_pkg::ST_PAUSE: begin
                if (tick) begin
                    if (pause_stretch
                        && sub != 4'(`STRETCH_FACTOR - 1)) begin
                        next_sub = sub + 4'h1;
                    end else begin
                        next_sub = 4'h0;
                        next_steps = steps + 9'h1;
                        step_hit = (steps + 9'h1
                                    == step_total(pause_time));
                    end
                end
                if (step_hit || !power_on_bit) begin
                    if (light_enable) begin
                        next_state = seq_pkg::ST_LIGHT;
                    end else begin
                        next_state = power_on_bit ? seq_pkg::ST_START
                                                  : seq_pkg::ST_SLEEP;
                    end
                end
            end
            seq_pkg::ST_LIGHT: begin
                step_hit = tick
                    && (steps + 9'h1 == step_total(light_integ_time));
                if (tick) begin
                    next_steps = steps + 9'h1;
                end
                if (step_hit) begin
                    light_latch = 1'b1;
                    next_state = power_on_bit ? seq_pkg::ST_START
                                              : seq_pkg::ST_SLEEP;
                end
            end
            default: begin
                next_state = seq_pkg::ST_SLEEP;
            end
        endcase
        if (restart) begin
            next_steps = 9'h0;
            next_sub = 4'h0;
        end
    end

    // Register file and result capture
    always_comb begin
        next_enable = enable;
        next_light_integ_time = light_integ_time;
        next_near_integ_time = near_integ_time;
        next_pause_time = pause_time;
        next_config_reg = config_reg;
        next_emitter_pulse_count = emitter_pulse_count;
        next_control = control;
        next_broadband_count = broadband_count;
        next_infrared_count = infrared_count;
        next_near_count = near_count;
        next_broad_hi_shadow = broad_hi_shadow;
        next_ir_hi_shadow = ir_hi_shadow;
        next_near_hi_shadow = near_hi_shadow;
        next_light_valid = light_valid;
        next_near_valid = near_valid;
        next_light_int = light_int;
        if (WR) begin
            case (ADDR)
                `ADDR_ENABLE: next_enable = WDATA;
                `ADDR_LIGHT_TIME: next_light_integ_time = WDATA;
                `ADDR_NEAR_TIME: next_near_integ_time = WDATA;
                `ADDR_PAUSE_TIME: next_pause_time = WDATA;
                `ADDR_CONFIG: next_config_reg = WDATA;
                `ADDR_PULSE_COUNT: next_emitter_pulse_count = WDATA;
                `ADDR_CONTROL: next_control = WDATA;
                `ADDR_STATUS: begin
                    // Write one to clear; a same-cycle set still wins below
                    next_light_valid = light_valid & ~WDATA[`BIT_LIGHT_VALID];
                    next_near_valid = near_valid & ~WDATA[`BIT_NEAR_VALID];
                    next_light_int = light_int & ~WDATA[`BIT_LIGHT_INT];
                end
                default: begin
                end
            endcase
        end
        // Low byte read freezes the high byte for the following read
        if (RD && ADDR == `ADDR_BROAD_LO) begin
            next_broad_hi_shadow = broadband_count[15:8];
        end
        if (RD && ADDR == `ADDR_IR_LO) begin
            next_ir_hi_shadow = infrared_count[15:8];
        end
        if (RD && ADDR == `ADDR_NEAR_LO) begin
            next_near_hi_shadow = near_count[15:8];
        end
        if (light_latch) begin
            next_broadband_count = BROADBAND_RESULT;
            next_infrared_count = INFRARED_RESULT;
            next_light_valid = 1'b1;
            next_light_int = 1'b1;
        end
        if (near_latch) begin
            next_near_count = NEAR_RESULT;
            next_near_valid = 1'b1;
        end
    end

    // Read mux; data appear the cycle after the strobe
    always_comb begin
        case (ADDR)
            `ADDR_ENABLE: read_value = enable;
            `ADDR_LIGHT_TIME: read_value = light_integ_time;
            `ADDR_NEAR_TIME: read_value = near_integ_time;
            `ADDR_PAUSE_TIME: read_value = pause_time;
            `ADDR_CONFIG: read_value = config_reg;
            `ADDR_PULSE_COUNT: read_value = emitter_pulse_count;
            `ADDR_CONTROL: read_value = control;
            `ADDR_STATUS: read_value = {state, light_int, 2'b00,
                                        near_valid, light_valid};
            `ADDR_BROAD_LO: read_value = broadband_count[7:0];
            `ADDR_BROAD_HI: read_value = broad_hi_shadow;
            `ADDR_IR_LO: read_value = infrared_count[7:0];
            `ADDR_IR_HI: read_value = ir_hi_shadow;
            `ADDR_NEAR_LO: read_value = near_count[7:0];
            `ADDR_NEAR_HI: read_value = near_hi_shadow;
            default: read_value = 8'h00;
        endcase
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            state <= seq_pkg::ST_SLEEP;
            steps <= 9'h000;
            sub <= 4'h0;
            enable <= `RST_ENABLE;
            light_integ_time <= `RST_TIME;
            near_integ_time <= `RST_TIME;
            pause_time <= `RST_TIME;
            config_reg <= `RST_CONFIG;
            emitter_pulse_count <= `RST_PULSE_COUNT;
            control <= `RST_CONTROL;
            broadband_count <= 16'h0000;
            infrared_count <= 16'h0000;
            near_count <= 16'h0000;
            broad_hi_shadow <= 8'h00;
            ir_hi_shadow <= 8'h00;
            near_hi_shadow <= 8'h00;
            light_valid <= 1'b0;
            near_valid <= 1'b0;
            light_int <= 1'b0;
            RDATA <= 8'h00;
            LIGHT_INTEGRATE <= 1'b0;
            NEAR_INTEGRATE <= 1'b0;
            LIGHT_GAIN_SEL <= 2'b00;
            NEAR_DIODE_SEL <= 2'b00;
            EMITTER_DRIVE_SEL <= 2'b00;
            LOW_POWER <= 1'b1;
            LIGHT_INT <= 1'b0;
        end else begin
            state <= next_state;
            steps <= next_steps;
            sub <= next_sub;
            enable <= next_enable;
            light_integ_time <= next_light_integ_time;
            near_integ_time <= next_near_integ_time;
            pause_time <= next_pause_time;
            config_reg <= next_config_reg;
            emitter_pulse_count <= next_emitter_pulse_count;
            control <= next_control;
            broadband_count <= next_broadband_count;
            infrared_count <= next_infrared_count;
            near_count <= next_near_count;
            broad_hi_shadow <= next_broad_hi_shadow;
            ir_hi_shadow <= next_ir_hi_shadow;
            near_hi_shadow <= next_near_hi_shadow;
            light_valid <= next_light_valid;
            near_valid <= next_near_valid;
            light_int <= next_light_int;
            RDATA <= RD ? read_value : 8'h00;
            LIGHT_INTEGRATE <= (next_state == seq_pkg::ST_LIGHT);
            NEAR_INTEGRATE <= (next_state == seq_pkg::ST_NEAR_PULSE)
                || (next_state == seq_pkg::ST_NEAR_INTEG);
            LIGHT_GAIN_SEL <= next_control[`POS_GAIN +: 2];
            NEAR_DIODE_SEL <= next_control[`POS_DIODE +: 2];
            EMITTER_DRIVE_SEL <= next_control[`POS_DRIVE +: 2];
            LOW_POWER <= (next_state == seq_pkg::ST_SLEEP);
            LIGHT_INT <= next_light_int && next_enable[`BIT_INT_EN];
        end
    end
endmodule : light_prox_measurement_sequencer
`default_nettype wire

//--- dv/seq_props.sv
// Port-level checks for the measurement sequencer
`timescale 1ns/100ps
`default_nettype none
`include "seq_map.svh"
module seq_props #(
    parameter int STEP_CYCLES = `STEP_CYCLES,
    parameter int PULSE_ON_CYCLES = `PULSE_ON_CYCLES
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // Register writes
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    // Sequencer outputs
    input wire logic LIGHT_INTEGRATE,
    input wire logic NEAR_INTEGRATE,
    input wire logic [1:0] LIGHT_GAIN_SEL,
    input wire logic [1:0] NEAR_DIODE_SEL,
    input wire logic [1:0] EMITTER_DRIVE_SEL,
    input wire logic EMITTER_SINK_PIN,
    input wire logic LOW_POWER,
    input wire logic LIGHT_INT
);
    logic [7:0] light_time;
    logic [7:0] ctl_w;
    logic int_en;
    int li_len;
    int on_len;
    int li_exp;
    // Assumes the bench leaves light time alone while integrating
    assign li_exp = (256 - int'(light_time)) * STEP_CYCLES;
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            light_time <= 8'hFF;
            ctl_w <= 8'h00;
            int_en <= 1'b0;
            li_len <= 0;
            on_len <= 0;
        end else begin
            if (WR && ADDR == `ADDR_LIGHT_TIME) light_time <= WDATA;
            if (WR && ADDR == `ADDR_CONTROL) ctl_w <= WDATA;
            if (WR && ADDR == `ADDR_ENABLE) int_en <= WDATA[`BIT_INT_EN];
            li_len <= LIGHT_INTEGRATE ? li_len + 1 : 0;
            on_len <= EMITTER_SINK_PIN ? on_len + 1 : 0;
        end
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    sequence s_wake;
        WR && ADDR == `ADDR_ENABLE && WDATA[0] && LOW_POWER;
    endsequence
    sequence s_ctl_write;
        WR && ADDR == `ADDR_CONTROL;
    endsequence
    chk_sleep_idle:
        assert property (LOW_POWER |-> !LIGHT_INTEGRATE && !NEAR_INTEGRATE)
        else $error("activity while asleep");
    chk_wake_delay:
        assert property (s_wake |=> (!LIGHT_INTEGRATE && !NEAR_INTEGRATE)[*8])
        else $error("measurement before the power-up step");
    chk_start_awake:
        assert property ($rose(LIGHT_INTEGRATE) |-> !LOW_POWER)
        else $error("light phase began from sleep");
    chk_sink_in_near:
        assert property (EMITTER_SINK_PIN |-> NEAR_INTEGRATE)
        else $error("emitter on outside proximity phase");
    chk_pulse_width:
        assert property ($fell(EMITTER_SINK_PIN) |-> on_len == PULSE_ON_CYCLES)
        else $error("emitter on time wrong");
    chk_light_length:
        assert property ($fell(LIGHT_INTEGRATE) |->
            li_len >= li_exp - 1 && li_len <= li_exp + 2)
        else $error("light integration length wrong");
    chk_ctl_fields:
        assert property (s_ctl_write |=> ##[0:1] (LIGHT_GAIN_SEL == ctl_w[1:0]
            && NEAR_DIODE_SEL == ctl_w[5:4] && EMITTER_DRIVE_SEL == ctl_w[7:6]))
        else $error("control fields not passed out");
    chk_int_cause:
        assert property ($fell(LIGHT_INTEGRATE) && int_en |-> ##[0:3] LIGHT_INT)
        else $error("light end did not raise interrupt");
    chk_sleep_quiet:
        assert property ($rose(LOW_POWER) && $past(LIGHT_INTEGRATE) |->
            li_len >= li_exp - 1)
        else $error("light conversion cut short by sleep");
endmodule : seq_props
bind light_prox_measurement_sequencer seq_props #(
    .STEP_CYCLES(STEP_CYCLES), .PULSE_ON_CYCLES(PULSE_ON_CYCLES)
) u_props (.CLK_SYS, .RST, .ADDR, .WDATA, .WR, .LIGHT_INTEGRATE,
    .NEAR_INTEGRATE, .LIGHT_GAIN_SEL, .NEAR_DIODE_SEL, .EMITTER_DRIVE_SEL,
    .EMITTER_SINK_PIN, .LOW_POWER, .LIGHT_INT);
`default_nettype wire

//--- dv/conv_model.sv
// Converter stand-in: fixed results per level, counts emitter pulses
`timescale 1ns/100ps
`default_nettype none
module conv_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Stimulus and observation
    input wire logic [7:0] level,
    input wire logic sink_on,
    output logic [15:0] broadband,
    output logic [15:0] infrared,
    output logic [15:0] near,
    output var int pulses
);
    logic sink_d;
    // Distinct low bytes expose swapped channels
    assign broadband = {level, 8'h11};
    assign infrared = {level, 8'h22};
    assign near = {level, 8'h33};
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sink_d <= 1'b0;
            pulses <= 0;
        end else begin
            sink_d <= sink_on;
            if (sink_on && !sink_d) pulses <= pulses + 1;
        end
    end
endmodule : conv_model
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench for the measurement sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam int STEP = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] level = 8'hA5;
    logic [7:0] rdata;
    logic [7:0] got;
    logic [15:0] bb, ir, nr;
    logic li, ni, sink, lp, lint;
    logic [1:0] gain, diode, drive;
    int pulses;
    int waited;
    int bad_count = 0;
    int cmp_count = 0;
    light_prox_measurement_sequencer #(.STEP_CYCLES(STEP)) u_dut (
        .CLK_SYS(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .BROADBAND_RESULT(bb),
        .INFRARED_RESULT(ir), .NEAR_RESULT(nr), .LIGHT_INTEGRATE(li),
        .NEAR_INTEGRATE(ni), .LIGHT_GAIN_SEL(gain), .NEAR_DIODE_SEL(diode),
        .EMITTER_DRIVE_SEL(drive), .EMITTER_SINK_PIN(sink),
        .LOW_POWER(lp), .LIGHT_INT(lint));
    conv_model u_conv (.clk(clk), .rst(rst), .level(level), .sink_on(sink),
        .broadband(bb), .infrared(ir), .near(nr), .pulses(pulses));
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask : cmp
    // Strobe drops for a cycle so no signal is set twice in one step
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        got = rdata;
    endtask : rd_reg
    task automatic rd_cmp(input logic [7:0] a, input logic [7:0] e);
        rd_reg(a);
        cmp(got, e);
    endtask : rd_cmp
    function automatic logic sig(input int sel);
        case (sel)
            0: return li;
            1: return lint;
            default: return lp;
        endcase
    endfunction : sig
    task automatic wait_for(input int sel, input logic v, input int lim);
        waited = 0;
        while (sig(sel) !== v && waited < lim) begin
            @(posedge clk);
            waited++;
        end
        if (waited >= lim) begin
            bad_count++;
            $display("ERROR %0t wait ran out", $time);
            test_done;
        end
    endtask : wait_for
    initial begin
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_cmp(8'h00, 8'h00);
        rd_cmp(8'h01, 8'hFF);
        rd_cmp(8'h03, 8'hFF);
        rd_cmp(8'h20, 8'h00);
        wr_reg(8'h00, 8'h06);
        repeat (100) @(posedge clk);
        cmp({7'h0, lp}, 8'h01);
        cmp({7'h0, li | ni}, 8'h00);
        $display("test sleep done");
        for (int i = 0; i < 4; i++) begin
            wr_reg(8'h06, {i[1:0], i[1:0], 2'b00, i[1:0]});
            @(posedge clk);
            cmp({6'h0, gain}, 8'(i));
            cmp({6'h0, diode}, 8'(i));
            cmp({6'h0, drive}, 8'(i));
        end
        $display("test fields done");
        wr_reg(8'h01, 8'hFE);
        wr_reg(8'h00, 8'h13);
        wait_for(1, 1'b1, 40 * STEP);
        rd_reg(8'h07);
        cmp(got & 8'h13, 8'h11);
        rd_cmp(8'h08, 8'h11);
        rd_cmp(8'h09, 8'hA5);
        rd_cmp(8'h0A, 8'h22);
        rd_cmp(8'h0B, 8'hA5);
        rd_cmp(8'h08, 8'h11);
        level <= 8'h5A;
        wr_reg(8'h07, 8'hFF);
        wait_for(1, 1'b0, 10);
        wait_for(1, 1'b1, 10 * STEP);
        rd_cmp(8'h09, 8'hA5);
        rd_cmp(8'h08, 8'h11);
        rd_cmp(8'h09, 8'h5A);
        $display("test light done");
        wr_reg(8'h04, 8'h02);
        wr_reg(8'h00, 8'h1B);
        wait_for(0, 1'b1, 40 * STEP);
        wait_for(0, 1'b0, 10 * STEP);
        wait_for(0, 1'b1, 40 * STEP);
        cmp(8'(waited >= 12 * STEP && waited <= 12 * STEP + 5), 8'h01);
        $display("test stretch done");
        wr_reg(8'h05, 8'h03);
        wr_reg(8'h07, 8'hFF);
        wr_reg(8'h00, 8'h17);
        got = 8'h00;
        for (int n = 0; n < 3000 && got[1] !== 1'b1; n++) rd_reg(8'h07);
        cmp(got & 8'h02, 8'h02);
        cmp(8'(pulses), 8'h03);
        rd_cmp(8'h0C, 8'h33);
        rd_cmp(8'h0D, 8'h5A);
        $display("test proximity done");
        wait_for(0, 1'b1, 4000);
        wr_reg(8'h07, 8'hFF);
        wr_reg(8'h00, 8'h00);
        wait_for(2, 1'b1, 20 * STEP);
        rd_reg(8'h07);
        cmp(got & 8'h01, 8'h01);
        repeat (100) @(posedge clk);
        cmp({7'h0, li | ni}, 8'h00);
        wr_reg(8'h01, 8'hED);
        rd_cmp(8'h01, 8'hED);
        $display("test power off done");
        test_done;
    end
endmodule : tb
`default_nettype wire
